/* File: core/oafe_status.v */
// primary interrupt status flags with an axi4-lite register slave
`include "oafe_regs.vh"

// Notes on behaviour
// [RULE1] eight flags, fixed order, reset to zero
// [RULE2] almost-full when next sample passes threshold
// [RULE3] almost-full clears on status or fifo read
// [RULE4] new-sample set on fifo entry, same clears
// [RULE5] ambient overflow clears on status read only
// [RULE6] proximity flag on first-slot threshold crossing
// [RULE7] proximity disabled runs full sequence at once
// [RULE8] host writes never change any flag
// [RULE9] proximity mode when result below 2048 times threshold
// [RULE10] proximity mode samples at 8Hz with pilot
// [RULE11] led compliance flag evaluated per sample end
// [RULE12] temperature flag clears on result or status read
// [RULE13] interrupt high while enabled flag set
module oafe_status #(
  parameter PROX_PERIOD = `OAFE_PROX_CYCLES
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire sample_store,
  input wire [6:0] fifo_level,
  input wire [7:0] fifo_data,
  input wire [15:0] temp_result,
  input wire ambient_cancel_overflow_flag,
  input wire sample_end,
  input wire led_driver_noncompliant,
  input wire temp_conv_done,
  input wire supply_range_flag,
  input wire power_up_flag,
  input wire slot1_valid,
  input wire [18:0] slot1_result,
  output wire full_sequence_start,
  output wire pilot_sample,
  output wire prox_mode,
  output wire irq
);

  // ************************************************************
  // declarations
  // ************************************************************
  reg [7:0] enable_reg;
  reg [16:0] ctrl_reg;
  reg [7:0] aw_addr_reg;
  reg aw_held_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg w_held_reg;
  reg [7:0] set_vec;
  reg [7:0] clr_vec;
  reg [31:0] rdata_next;
  reg [1:0] rresp_next;
  wire [7:0] flags;
  wire [6:0] afull_threshold;
  wire clear_on_fifo_read;
  wire [7:0] proximity_threshold;
  wire prox_enable;
  wire prox_cross;
  wire rd_take;
  wire wr_fire;
  wire rd_status;
  wire rd_fifo;
  wire rd_temp;
  wire fifo_clr;
  wire [7:0] next_level;
  wire wr_flags;
  wire wr_enable;
  wire wr_ctrl;
  wire wr_mapped;

  // register map by byte address:
  //   flags   status byte, read clears, writes ignored
  //   enable  interrupt enables in bits 7..1
  //   ctrl    afull threshold, fifo-read clear, proximity threshold and enable
  //   state   bit 0 shows proximity mode
  //   fifo    fifo data byte, read-only
  //   temp    temperature result, read-only

  // control register fields
  assign afull_threshold = ctrl_reg[`OAFE_CTRL_THR_MSB:`OAFE_CTRL_THR_LSB];
  assign clear_on_fifo_read = ctrl_reg[`OAFE_CTRL_FIFOCLR];
  assign proximity_threshold = ctrl_reg[`OAFE_CTRL_PTHR_MSB:`OAFE_CTRL_PTHR_LSB];
  assign prox_enable = ctrl_reg[`OAFE_CTRL_PROXEN];

  // write decode on the full byte address, so that the response code
  // and the register update always agree
  assign wr_flags = (aw_addr_reg == `OAFE_ADDR_FLAGS);
  assign wr_enable = (aw_addr_reg == `OAFE_ADDR_ENABLE);
  assign wr_ctrl = (aw_addr_reg == `OAFE_ADDR_CTRL);
  assign wr_mapped = wr_flags || wr_enable || wr_ctrl;

  // ************************************************************
  // axi4-lite handshakes
  // ************************************************************
  // address and data are latched separately; response follows both
  // awready and wready each stay low while its own half is held or bvalid is up,
  // so a second write waits until the first response is taken
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign wr_fire = aw_held_reg && w_held_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `OAFE_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // read-only and unmapped addresses answer with a slave error
        if (wr_mapped) begin
          s_axi_bresp <= `OAFE_RESP_OKAY;
        end else begin
          s_axi_bresp <= `OAFE_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // writable registers
  // ************************************************************
  // the status byte accepts writes and ignores them
  // enable bit 0 is stored but has no flag to gate
  // control bytes follow the write strobes; bit 16 sits in byte 2
  always @(posedge aclk) begin
    if (!aresetn) begin
      enable_reg <= `OAFE_ENABLE_RST;
      ctrl_reg <= `OAFE_CTRL_RST;
    end else if (wr_fire) begin
      if (wr_enable && w_strb_reg[0]) begin
        enable_reg <= w_data_reg[7:0];
      end
      if (wr_ctrl) begin
        if (w_strb_reg[0]) begin
          ctrl_reg[7:0] <= w_data_reg[7:0];
        end
        if (w_strb_reg[1]) begin
          ctrl_reg[15:8] <= w_data_reg[15:8];
        end
        if (w_strb_reg[2]) begin
          ctrl_reg[16] <= w_data_reg[16];
        end
      end
    end
  end

  // ************************************************************
  // read side and its clearing effects
  // ************************************************************
  // a status read clears the flags at the edge that takes the address;
  // the data register captures the byte before the clear at that edge,
  // and an event in the same cycle survives for the next read
  assign rd_status = rd_take && (s_axi_araddr == `OAFE_ADDR_FLAGS);
  assign rd_fifo = rd_take && (s_axi_araddr == `OAFE_ADDR_FIFO);
  assign rd_temp = rd_take && (s_axi_araddr == `OAFE_ADDR_TEMP);
  assign fifo_clr = rd_fifo && clear_on_fifo_read;

  // read data mux
  // unmapped addresses read zero with a slave error
  always @* begin
    rdata_next = 32'h00000000;
    rresp_next = `OAFE_RESP_OKAY;
    case (s_axi_araddr)
      `OAFE_ADDR_FLAGS: rdata_next = {24'h000000, flags};
      `OAFE_ADDR_ENABLE: rdata_next = {24'h000000, enable_reg};
      `OAFE_ADDR_CTRL: rdata_next = {15'h0000, ctrl_reg};
      `OAFE_ADDR_STATE: rdata_next = {31'h00000000, prox_mode};
      `OAFE_ADDR_FIFO: rdata_next = {24'h000000, fifo_data};
      `OAFE_ADDR_TEMP: rdata_next = {16'h0000, temp_result};
      default: rresp_next = `OAFE_RESP_SLVERR;
    endcase
  end

  // read answer: one edge after the address is taken, held until rready
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `OAFE_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_next;
      s_axi_rresp <= rresp_next;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // flag set and clear terms
  // ************************************************************
  // fifo level once the store under way has landed
  assign next_level = {1'b0, fifo_level} + 8'h01;

  // each set term is one cycle of its source event, each clear term one
  // cycle of the qualifying read
  // almost-full and new-sample also clear on a fifo data read when the
  // clear-on-fifo-read bit is set; temperature also on a result read
  // ambient overflow, proximity, compliance, supply and power clear only
  // on a status read
  always @* begin
    set_vec = 8'h00;
    set_vec[`OAFE_BIT_AFULL] = sample_store && (next_level > {1'b0, afull_threshold}); // RULE2
    set_vec[`OAFE_BIT_NEWSMP] = sample_store; // RULE4
    set_vec[`OAFE_BIT_AMBOVF] = ambient_cancel_overflow_flag; // RULE5
    set_vec[`OAFE_BIT_PROX] = prox_cross && prox_enable; // RULE6
    set_vec[`OAFE_BIT_LEDCMP] = sample_end && led_driver_noncompliant; // RULE11
    set_vec[`OAFE_BIT_TEMP] = temp_conv_done; // RULE12
    set_vec[`OAFE_BIT_SUPPLY] = supply_range_flag;
    set_vec[`OAFE_BIT_PWR] = power_up_flag;
    clr_vec = {8{rd_status}};
    clr_vec[`OAFE_BIT_AFULL] = rd_status || fifo_clr; // RULE3
    clr_vec[`OAFE_BIT_NEWSMP] = rd_status || fifo_clr; // RULE4
    clr_vec[`OAFE_BIT_TEMP] = rd_status || rd_temp; // RULE12
  end

  // one cell per flag; no write path reaches them
  // set and clear meet in each cell, where the set wins
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_flag
      oafe_flag_cell u_cell ( // RULE1 RULE8
        .aclk(aclk),
        .aresetn(aresetn),
        .set_pulse(set_vec[i]),
        .clr_pulse(clr_vec[i]),
        .flag_reg(flags[i])
      );
    end
  endgenerate

  // ************************************************************
  // proximity control
  // ************************************************************
  // the crossing pulse reaches its flag only while detection is enabled
  // pilot ticks come from the sub-block's own slow counter
  oafe_prox_ctl #(
    .PROX_PERIOD(PROX_PERIOD)
  ) u_prox (
    .aclk(aclk),
    .aresetn(aresetn),
    .prox_enable(prox_enable),
    .proximity_threshold(proximity_threshold),
    .slot1_valid(slot1_valid),
    .slot1_result(slot1_result),
    .prox_mode_reg(prox_mode),
    .prox_cross_reg(prox_cross),
    .pilot_tick_reg(pilot_sample)
  );

  // full sequence runs whenever not held in proximity mode
  assign full_sequence_start = !prox_mode; // RULE7

  // ************************************************************
  // interrupt output
  // ************************************************************
  // power-up flag has no enable bit and is not gated onto the line
  // the line follows flags and enables directly, so it drops in the
  // cycle after the read that clears the last enabled flag
  assign irq = |(flags[7:1] & enable_reg[7:1]); // RULE13

endmodule // oafe_status

/* File: inc/oafe_regs.vh */
// register offsets, field positions, reset values and timing counts of the status block
`ifndef OAFE_REGS_VH
`define OAFE_REGS_VH

// ************************************************************
// register byte addresses
// ************************************************************
`define OAFE_ADDR_FLAGS 8'h00
`define OAFE_ADDR_ENABLE 8'h04
`define OAFE_ADDR_CTRL 8'h08
`define OAFE_ADDR_STATE 8'h0C
`define OAFE_ADDR_FIFO 8'h10
`define OAFE_ADDR_TEMP 8'h14

// ************************************************************
// flag bit positions in the primary status byte
// ************************************************************
`define OAFE_BIT_AFULL 7
`define OAFE_BIT_NEWSMP 6
`define OAFE_BIT_AMBOVF 5
`define OAFE_BIT_PROX 4
`define OAFE_BIT_LEDCMP 3
`define OAFE_BIT_TEMP 2
`define OAFE_BIT_SUPPLY 1
`define OAFE_BIT_PWR 0

// ************************************************************
// control register fields
// ************************************************************
`define OAFE_CTRL_THR_LSB 0
`define OAFE_CTRL_THR_MSB 6
`define OAFE_CTRL_FIFOCLR 7
`define OAFE_CTRL_PTHR_LSB 8
`define OAFE_CTRL_PTHR_MSB 15
`define OAFE_CTRL_PROXEN 16

// ************************************************************
// reset values and constants
// ************************************************************
`define OAFE_FLAGS_RST 8'h00
`define OAFE_ENABLE_RST 8'h00
`define OAFE_CTRL_RST 17'h00000
`define OAFE_PROX_SCALE 12'h800
`define OAFE_CLK_HZ 25000000
`define OAFE_PROX_RATE_HZ 8
`define OAFE_PROX_CYCLES (`OAFE_CLK_HZ / `OAFE_PROX_RATE_HZ)
`define OAFE_RESP_OKAY 2'h0
`define OAFE_RESP_SLVERR 2'h2

`endif

/* File: core/oafe_flag_cell.v */
// one sticky event flag: set wins over clear
module oafe_flag_cell (
  input wire aclk,
  input wire aresetn,
  input wire set_pulse,
  input wire clr_pulse,
  output reg flag_reg
);

  // ************************************************************
  // flag storage
  // ************************************************************
  // set has priority so an event in the clearing cycle survives
  always @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= 1'b0;
    end else if (set_pulse) begin
      flag_reg <= 1'b1;
    end else if (clr_pulse) begin
      flag_reg <= 1'b0;
    end
  end

endmodule // oafe_flag_cell

/* File: core/oafe_prox_ctl.v */
// proximity mode decision and slow pilot sample pacing
`include "oafe_regs.vh"

module oafe_prox_ctl #(
  parameter PROX_PERIOD = `OAFE_PROX_CYCLES
) (
  input wire aclk,
  input wire aresetn,
  input wire prox_enable,
  input wire [7:0] proximity_threshold,
  input wire slot1_valid,
  input wire [18:0] slot1_result,
  output reg prox_mode_reg,
  output reg prox_cross_reg,
  output reg pilot_tick_reg
);

  wire [19:0] limit;
  wire below;
  reg [23:0] tick_cnt_reg;

  // last count of one slow period, cut to the counter width on purpose
  localparam [31:0] PROX_LAST = PROX_PERIOD - 1;

  // ************************************************************
  // mode decision on each first-slot result
  // ************************************************************
  assign limit = {proximity_threshold, 12'h000}; // threshold times 2048 shifted by 11 plus pad
  assign below = ({slot1_result, 1'b0} < limit);

  // crossing pulse when a first-slot result changes the mode; dropping the mode by disabling gives none
  always @(posedge aclk) begin
    if (!aresetn) begin
      prox_mode_reg <= 1'b0;
      prox_cross_reg <= 1'b0;
    end else begin
      prox_cross_reg <= 1'b0;
      if (!prox_enable) begin
        prox_mode_reg <= 1'b0; // RULE7
      end else if (slot1_valid) begin
        prox_mode_reg <= below; // RULE9
        prox_cross_reg <= (below != prox_mode_reg); // RULE6
      end
    end
  end

  // ************************************************************
  // pilot sample pacing at the slow rate
  // ************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_reg <= 24'h000000;
      pilot_tick_reg <= 1'b0;
    end else if (!prox_mode_reg) begin
      tick_cnt_reg <= 24'h000000;
      pilot_tick_reg <= 1'b0;
    end else if (tick_cnt_reg == PROX_LAST[23:0]) begin
      tick_cnt_reg <= 24'h000000;
      pilot_tick_reg <= 1'b1; // RULE10
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 24'h000001;
      pilot_tick_reg <= 1'b0;
    end
  end

endmodule // oafe_prox_ctl

/* File: verif/oafe_status_asserts.sv */
// concurrent checks on the ports of the status block
`include "oafe_regs.vh"
module oafe_status_asserts #(
  parameter PROX_PERIOD = `OAFE_PROX_CYCLES
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire sample_store,
  input wire ambient_cancel_overflow_flag,
  input wire sample_end,
  input wire temp_conv_done,
  input wire supply_range_flag,
  input wire power_up_flag,
  input wire slot1_valid,
  input wire full_sequence_start,
  input wire pilot_sample,
  input wire prox_mode,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // helpers
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire quiet = !(sample_store | ambient_cancel_overflow_flag | sample_end | temp_conv_done |
    supply_range_flag | power_up_flag | slot1_valid);
  // ************************************************************
  // assertions
  // ************************************************************
  AST_RESET_IDLE: assert property ($rose(aresetn) |-> !irq && !s_axi_rvalid && !s_axi_bvalid)
    else $error("outputs not idle after reset");
  AST_STATUS_CLEAR: assert property (ar_take && s_axi_araddr == `OAFE_ADDR_FLAGS && quiet &&
    !$past(slot1_valid) |=> !irq) else $error("irq stays after status read");
  AST_SEQ_START: assert property (full_sequence_start == !prox_mode)
    else $error("sequence start disagrees with mode");
  AST_PILOT_ONLY_PROX: assert property (!prox_mode [*3] |-> !pilot_sample)
    else $error("pilot sample outside proximity mode");
  AST_PILOT_PULSE: assert property (pilot_sample |=> !pilot_sample)
    else $error("pilot sample wider than one cycle");
  AST_READ_LATENCY: assert property (ar_take |=> s_axi_rvalid) else $error("read answer late");
  AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer moved");
  AST_WRITE_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
    $stable(s_axi_bresp)) else $error("write answer moved");
  AST_UNMAPPED_READ: assert property (ar_take && s_axi_araddr > 8'h14 |=>
    s_axi_rresp == `OAFE_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
  AST_ONE_READ: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read taken");
  AST_PROX_ENTRY: assert property ($rose(prox_mode) |-> $past(slot1_valid))
    else $error("proximity mode entered without a first-slot result");
  // main scenarios reached
  cover property (ar_take && s_axi_araddr == `OAFE_ADDR_FLAGS);
  cover property (pilot_sample);
  cover property ($rose(irq));
endmodule // oafe_status_asserts
bind oafe_status oafe_status_asserts #(.PROX_PERIOD(PROX_PERIOD)) chk (.*);

/* File: verif/oafe_host.sv */
// axi4-lite master model standing in for the host processor
module oafe_host (
  input wire aclk,
  output reg [7:0] s_axi_awaddr = 8'h00,
  output reg [2:0] s_axi_awprot = 3'h0,
  output reg s_axi_awvalid = 1'b0,
  input wire s_axi_awready,
  output reg [31:0] s_axi_wdata = 32'h0,
  output reg [3:0] s_axi_wstrb = 4'hF,
  output reg s_axi_wvalid = 1'b0,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output reg s_axi_bready = 1'b0,
  output reg [7:0] s_axi_araddr = 8'h00,
  output reg [2:0] s_axi_arprot = 3'h0,
  output reg s_axi_arvalid = 1'b0,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output reg s_axi_rready = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // bus cycles; handshakes sampled at the falling edge before the rising one
  // ************************************************************
  task automatic wr(input [7:0] a, input [31:0] d, output [1:0] r);
    reg ta, tw, t;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(negedge aclk);
        ta = s_axi_awvalid && s_axi_awready;
        tw = s_axi_wvalid && s_axi_wready;
        t = (ta || !s_axi_awvalid) && (tw || !s_axi_wvalid);
        @(posedge aclk);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
      end while (!t);
      do begin
        @(negedge aclk);
        t = s_axi_bvalid;
        r = s_axi_bresp;
        @(posedge aclk);
      end while (!t);
      s_axi_bready <= 1'b0;
    end
  endtask
  task automatic rd(input [7:0] a, output [31:0] d, output [1:0] r);
    reg t;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(negedge aclk);
        t = s_axi_arready;
        @(posedge aclk);
      end while (!t);
      s_axi_arvalid <= 1'b0;
      do begin
        @(negedge aclk);
        t = s_axi_rvalid;
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge aclk);
      end while (!t);
      s_axi_rready <= 1'b0;
    end
  endtask
endmodule // oafe_host

/* File: verif/optical_afe_interrupt_status_test.sv */
// self-checking bench for the primary status flags
`include "oafe_regs.vh"
module optical_afe_interrupt_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed { logic [7:0] ev; logic [6:0] lvl; logic [7:0] flags; } oafe_row_t;
  reg aclk = 1'b0, aresetn = 1'b0, sample_store = 1'b0, ambient_cancel_overflow_flag = 1'b0;
  reg sample_end = 1'b0, led_driver_noncompliant = 1'b0, temp_conv_done = 1'b0;
  reg supply_range_flag = 1'b0, power_up_flag = 1'b0, slot1_valid = 1'b0;
  reg [6:0] fifo_level = 7'h00;
  reg [7:0] fifo_data = 8'h5A;
  reg [15:0] temp_result = 16'hA5C3;
  reg [18:0] slot1_result = 19'h00000;
  wire [7:0] s_axi_awaddr, s_axi_araddr;
  wire [2:0] s_axi_awprot, s_axi_arprot;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire full_sequence_start, pilot_sample, prox_mode, irq;
  int miscompares = 0, samples_checked = 0, n;
  oafe_row_t rows [8] = '{'{8'h80, 7'h0A, 8'hC0}, '{8'h80, 7'h09, 8'h40}, '{8'h20, 7'h0, 8'h20},
    '{8'h08, 7'h0, 8'h08}, '{8'h04, 7'h0, 8'h04}, '{8'h02, 7'h0, 8'h02},
    '{8'h01, 7'h0, 8'h01}, '{8'h2F, 7'h0, 8'h2F}};
  oafe_status #(.PROX_PERIOD(10)) dut (.*);
  oafe_host host (.*);
  // ************************************************************
  // clock and helpers
  // ************************************************************
  always #20 aclk = ~aclk;
  task automatic chk(input string s, input [31:0] e, input [31:0] g);
    begin
      samples_checked++;
      if (g !== e) begin
        miscompares++;
        $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
    end
  endtask
  task automatic rc(input [7:0] a, input [31:0] e, input [1:0] er);
    reg [31:0] d;
    reg [1:0] r;
    begin
      host.rd(a, d, r);
      chk($sformatf("read %h", a), e, d);
      chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, r});
    end
  endtask
  task automatic wc(input [7:0] a, input [31:0] d, input [1:0] er);
    reg [1:0] r;
    begin
      host.wr(a, d, r);
      chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, r});
    end
  endtask
  task automatic pins(input string s, input [2:0] e);
    begin
      @(negedge aclk);
      chk(s, {29'h0, e}, {29'h0, irq, prox_mode, full_sequence_start});
    end
  endtask
  task automatic pulse(input [7:0] ev, input [6:0] lvl, input [18:0] res);
    begin
      @(posedge aclk);
      {sample_store, ambient_cancel_overflow_flag, slot1_valid} <= {ev[7], ev[5], ev[4]};
      {sample_end, led_driver_noncompliant, temp_conv_done} <= {ev[3], ev[3], ev[2]};
      {supply_range_flag, power_up_flag, fifo_level, slot1_result} <= {ev[1:0], lvl, res};
      @(posedge aclk);
      {sample_store, ambient_cancel_overflow_flag, slot1_valid, sample_end} <= 4'h0;
      {temp_conv_done, supply_range_flag, power_up_flag} <= 3'h0;
      repeat (3) @(posedge aclk);
    end
  endtask
  task automatic close_out;
    begin
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  // watchdog cuts a hang short
  initial begin
    #(40 * 6000);
    miscompares++;
    close_out;
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (4) @(posedge aclk);
    pins("reset pins", 3'b001);
    @(posedge aclk);
    aresetn <= 1'b1;
    rc(`OAFE_ADDR_FLAGS, 32'h0, `OAFE_RESP_OKAY);
    wc(`OAFE_ADDR_CTRL, 32'h1018A, `OAFE_RESP_OKAY);
    wc(`OAFE_ADDR_ENABLE, 32'hFE, `OAFE_RESP_OKAY);
    foreach (rows[i]) begin
      pulse(rows[i].ev, rows[i].lvl, 19'h0);
      pins("irq set", {|(rows[i].flags & 8'hFE), 2'b01});
      rc(`OAFE_ADDR_FLAGS, {24'h0, rows[i].flags}, `OAFE_RESP_OKAY);
      rc(`OAFE_ADDR_FLAGS, 32'h0, `OAFE_RESP_OKAY);
      pins("irq clear", 3'b001);
      $display("row %0d done", i);
    end
    pulse(8'h20, 7'h0, 19'h0);
    wc(`OAFE_ADDR_FLAGS, 32'hFFFFFFFF, `OAFE_RESP_OKAY);
    rc(`OAFE_ADDR_FLAGS, 32'h20, `OAFE_RESP_OKAY);
    pulse(8'hA0, 7'h0A, 19'h0);
    rc(`OAFE_ADDR_FIFO, {24'h0, fifo_data}, `OAFE_RESP_OKAY);
    rc(`OAFE_ADDR_FLAGS, 32'h20, `OAFE_RESP_OKAY);
    wc(`OAFE_ADDR_CTRL, 32'h1010A, `OAFE_RESP_OKAY);
    pulse(8'h80, 7'h00, 19'h0);
    rc(`OAFE_ADDR_FIFO, {24'h0, fifo_data}, `OAFE_RESP_OKAY);
    rc(`OAFE_ADDR_FLAGS, 32'h40, `OAFE_RESP_OKAY);
    pulse(8'h04, 7'h0, 19'h0);
    rc(`OAFE_ADDR_TEMP, {16'h0, temp_result}, `OAFE_RESP_OKAY);
    rc(`OAFE_ADDR_FLAGS, 32'h0, `OAFE_RESP_OKAY);
    rc(8'h20, 32'h0, `OAFE_RESP_SLVERR);
    wc(8'h20, 32'h1, `OAFE_RESP_SLVERR);
    $display("clearing tests done");
    pulse(8'h10, 7'h0, 19'd2047);
    pins("prox entry", 3'b110);
    n = 0;
    repeat (30) begin
      @(negedge aclk);
      n += pilot_sample;
    end
    chk("pilot count", 32'd3, n);
    rc(`OAFE_ADDR_FLAGS, 32'h10, `OAFE_RESP_OKAY);
    pulse(8'h10, 7'h0, 19'd2048);
    pins("prox exit", 3'b101);
    rc(`OAFE_ADDR_FLAGS, 32'h10, `OAFE_RESP_OKAY);
    wc(`OAFE_ADDR_CTRL, 32'h0010A, `OAFE_RESP_OKAY);
    pulse(8'h10, 7'h0, 19'h0);
    pins("prox off", 3'b001);
    rc(`OAFE_ADDR_FLAGS, 32'h0, `OAFE_RESP_OKAY);
    $display("proximity tests done");
    wc(`OAFE_ADDR_ENABLE, 32'h02, `OAFE_RESP_OKAY);
    pulse(8'h20, 7'h0, 19'h0);
    pins("irq masked", 3'b001);
    pulse(8'h02, 7'h0, 19'h0);
    pins("irq unmasked", 3'b101);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    pins("reset again", 3'b001);
    rc(`OAFE_ADDR_FLAGS, 32'h0, `OAFE_RESP_OKAY);
    rc(`OAFE_ADDR_ENABLE, {24'h0, `OAFE_ENABLE_RST}, `OAFE_RESP_OKAY);
    $display("mask and reset tests done");
    close_out;
  end
endmodule // optical_afe_interrupt_status_test
